// ===== logic/usbifm_status_regs.sv
// Purpose: Register-controlled USB interface manager status and event logic
//          between the peripheral register port and a UTMI+ transceiver.
// Assumes: All inputs synchronous to clock_in; 32-bit register accesses.
// Notes:   A write of any value to the soft reset offset restores every
//          register to its reset value, as rst_n_in does.
//
// Summary of operation
// - Session flags mirror six transceiver session indications.
// - Serial control reports differential, D-minus, D-plus receive.
// - Serial bits drive SE0 request and transmit data.
// - Bit 1 is active-low transmit enable, resets high.
// - Bit 0 selects full/low-speed serial mode, resets zero.
// - Non-sticky token and CRC16 flags clear when next packet begins.
// - Bit 6 sets on valid, addressed token.
// - Bits 5,4,3 set on SE0, K, J line.
// - Bit 2 sets on data CRC16 failure.
// - Bits 1,0 follow receive active and error.
// - Sticky flags hold until software writes one.
// - Non-sticky line and receive flags are overwritten by signal changes.
// - Mask bytes OR selected flags onto four ports.
// - Eleven-bit frame counter readable, writable, resets zero.
// - Last packet identifier captured read-only, resets zero.
// - Last endpoint stored, bit 4 marks it valid.
// - Marked endpoints appear on receive port ORed 0x10.
// - Only tokens for stored device address pass.
`timescale 1ns/1ps
`include "usbifm_consts.svh"

module usbifm_status_regs (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Peripheral register port
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  output logic             reg_rdata_valid_out,
  // Transceiver session indications
  input  wire logic        b_session_valid_flag_in,
  input  wire logic        id_ground_flag_in,
  input  wire logic        host_disconnect_flag_in,
  input  wire logic        bus_voltage_valid_flag_in,
  input  wire logic        session_valid_flag_in,
  input  wire logic        session_end_flag_in,
  // Transceiver serial receive and line
  input  wire logic        differential_receive_value_in,
  input  wire logic        dminus_receive_value_in,
  input  wire logic        dplus_receive_value_in,
  input  wire logic [1:0]  line_state_in,
  input  wire logic        transceiver_receive_active_in,
  input  wire logic        transceiver_receive_error_in,
  // Packet decoder events
  input  wire logic        packet_start_in,
  input  wire logic        pid_valid_in,
  input  wire logic [3:0]  pid_in,
  input  wire logic        token_valid_in,
  input  wire logic [6:0]  token_address_in,
  input  wire logic [3:0]  token_endpoint_in,
  input  wire logic        crc16_fail_in,
  input  wire logic        frame_start_valid_in,
  input  wire logic [10:0] frame_number_in,
  // Transceiver serial transmit control
  output logic             transmit_single_ended_zero_out,
  output logic             serial_transmit_value_out,
  output logic             transmit_enable_low_out,
  output logic             full_low_speed_serial_select_out,
  // Event ports and receive endpoint port
  output logic      [3:0]  event_port_out,
  output logic      [4:0]  rx_endpoint_out,
  output logic             rx_endpoint_valid_out
);
  import usbifm_pkg::*;

  usbifm_state_t state;
  usbifm_state_t next_state;

  logic [6:0] flag_cond;
  logic [6:0] flag_level;
  logic       token_match;
  logic       wr_flags;
  logic       soft_reset;
  logic [31:0] read_mux;

  assign token_match = token_valid_in &&
                       (token_address_in == state.device_address);
  assign wr_flags    = reg_write_in &&
                       (reg_addr_in == `USBIFM_OFF_EVENT_FLAGS);
  assign soft_reset  = reg_write_in &&
                       (reg_addr_in == `USBIFM_OFF_SOFT_RESET);

  // Conditions that set each flag this cycle
  always_comb begin
    flag_cond = 7'h00;
    flag_cond[`USBIFM_FLG_TOKEN] = token_match;
    flag_cond[`USBIFM_FLG_SE0]   = (line_state_in == `USBIFM_LS_SE0);
    flag_cond[`USBIFM_FLG_K]     = (line_state_in == `USBIFM_LS_K);
    flag_cond[`USBIFM_FLG_J]     = (line_state_in == `USBIFM_LS_J);
    flag_cond[`USBIFM_FLG_CRC16] = crc16_fail_in;
    flag_cond[`USBIFM_FLG_RXACT] = transceiver_receive_active_in;
    flag_cond[`USBIFM_FLG_RXERR] = transceiver_receive_error_in;
  end

  // Line and receive flags track their signal; packet events latch
  assign flag_level = 7'b0111011;

  // Event ports: any selected flag raises the port
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      assign event_port_out[p] =
        |(state.port_masks[p*8 +: 7] & state.event_flags);
    end
  endgenerate

  // Read mux; unused and reserved bits stay zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (reg_addr_in)
      `USBIFM_OFF_DEVICE_ADDRESS: read_mux[6:0] = state.device_address;
      `USBIFM_OFF_SESSION_FLAGS: read_mux[5:0] = {b_session_valid_flag_in,
        id_ground_flag_in, host_disconnect_flag_in,
        bus_voltage_valid_flag_in, session_valid_flag_in,
        session_end_flag_in};
      `USBIFM_OFF_SERIAL_CTRL: read_mux[6:0] = {
        differential_receive_value_in, dminus_receive_value_in,
        dplus_receive_value_in, state.serial_ctrl};
      `USBIFM_OFF_EVENT_FLAGS:   read_mux[6:0]  = state.event_flags;
      `USBIFM_OFF_HOLD_SELECT:   read_mux[6:0]  = state.hold_select;
      `USBIFM_OFF_PORT_MASKS:    read_mux       = state.port_masks;
      `USBIFM_OFF_FRAME_COUNT:   read_mux[10:0] = state.frame_count;
      `USBIFM_OFF_LAST_PID:      read_mux[3:0]  = state.last_pid;
      `USBIFM_OFF_LAST_ENDPOINT: read_mux[4:0]  = state.last_endpoint;
      `USBIFM_OFF_ENDPOINT_MARKS: read_mux[15:0] = state.endpoint_marks;
      default:                   read_mux       = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.read_valid = reg_read_in;
    next_state.read_data  = reg_read_in ? read_mux : 32'h0000_0000;
    next_state.rx_endpoint_valid = 1'b0;

    // Register writes; full words only, reserved bits dropped
    if (reg_write_in) begin
      unique case (reg_addr_in)
        `USBIFM_OFF_DEVICE_ADDRESS:
          next_state.device_address = reg_wdata_in[6:0];
        `USBIFM_OFF_SERIAL_CTRL:
          next_state.serial_ctrl = reg_wdata_in[3:0];
        `USBIFM_OFF_HOLD_SELECT:
          next_state.hold_select = reg_wdata_in[6:0];
        `USBIFM_OFF_PORT_MASKS:
          next_state.port_masks = reg_wdata_in;
        `USBIFM_OFF_FRAME_COUNT:
          next_state.frame_count = reg_wdata_in[10:0];
        `USBIFM_OFF_ENDPOINT_MARKS:
          next_state.endpoint_marks = reg_wdata_in[15:0];
        default: ;
      endcase
    end

    // Flag update; a set in the clearing cycle wins
    for (int i = 0; i < 7; i++) begin
      if (state.hold_select[i]) begin
        if (wr_flags && reg_wdata_in[i])
          next_state.event_flags[i] = 1'b0;
        if (flag_cond[i])
          next_state.event_flags[i] = 1'b1;
      end else if (flag_level[i]) begin
        next_state.event_flags[i] = flag_cond[i];
      end else begin
        if (packet_start_in || (wr_flags && reg_wdata_in[i]))
          next_state.event_flags[i] = 1'b0;
        if (flag_cond[i])
          next_state.event_flags[i] = 1'b1;
      end
    end

    // Frame number from each start-of-frame token
    if (frame_start_valid_in)
      next_state.frame_count = frame_number_in;

    if (pid_valid_in)
      next_state.last_pid = pid_in;

    if (token_match) begin
      next_state.last_endpoint = {1'b1, token_endpoint_in};
      next_state.rx_endpoint_valid = 1'b1;
      next_state.rx_endpoint = {1'b0, token_endpoint_in} |
        (state.endpoint_marks[token_endpoint_in] ?
         `USBIFM_EP_MARK : 5'h00);
    end

    // Soft reset restores all register state, read answer still given
    if (soft_reset) begin
      next_state = '0;
      next_state.serial_ctrl = `USBIFM_SER_RESET;
      next_state.read_valid  = reg_read_in;
      next_state.read_data   = reg_read_in ? read_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.serial_ctrl <= `USBIFM_SER_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_out       = state.read_data;
  assign reg_rdata_valid_out = state.read_valid;
  assign rx_endpoint_out     = state.rx_endpoint;
  assign rx_endpoint_valid_out = state.rx_endpoint_valid;

  // Serial line controls straight from the register bits
  assign transmit_single_ended_zero_out =
    state.serial_ctrl[`USBIFM_SER_SE0_BIT];
  assign serial_transmit_value_out =
    state.serial_ctrl[`USBIFM_SER_DATA_BIT];
  assign transmit_enable_low_out =
    state.serial_ctrl[`USBIFM_SER_TXENN_BIT];
  assign full_low_speed_serial_select_out =
    state.serial_ctrl[`USBIFM_SER_FSLS_BIT];

endmodule : usbifm_status_regs

// ===== pkg/usbifm_consts.svh
// Purpose: Offsets, field positions and reset values of the USB interface
//          manager status registers.
// Assumes: Word offsets on the peripheral register port.
// Notes:   Definitions only.
`ifndef USBIFM_CONSTS_SVH
`define USBIFM_CONSTS_SVH

`define USBIFM_OFF_SOFT_RESET     8'h00
`define USBIFM_OFF_DEVICE_ADDRESS 8'h08
`define USBIFM_OFF_SESSION_FLAGS  8'h14
`define USBIFM_OFF_SERIAL_CTRL    8'h18
`define USBIFM_OFF_EVENT_FLAGS    8'h1c
`define USBIFM_OFF_HOLD_SELECT    8'h20
`define USBIFM_OFF_PORT_MASKS     8'h24
`define USBIFM_OFF_FRAME_COUNT    8'h28
`define USBIFM_OFF_LAST_PID       8'h2c
`define USBIFM_OFF_LAST_ENDPOINT  8'h30
`define USBIFM_OFF_ENDPOINT_MARKS 8'h34

// Serial control field positions
`define USBIFM_SER_DIFF_BIT  6
`define USBIFM_SER_DM_BIT    5
`define USBIFM_SER_DP_BIT    4
`define USBIFM_SER_SE0_BIT   3
`define USBIFM_SER_DATA_BIT  2
`define USBIFM_SER_TXENN_BIT 1
`define USBIFM_SER_FSLS_BIT  0
`define USBIFM_SER_RESET     4'h2

// Event flag positions
`define USBIFM_FLG_TOKEN   6
`define USBIFM_FLG_SE0     5
`define USBIFM_FLG_K       4
`define USBIFM_FLG_J       3
`define USBIFM_FLG_CRC16   2
`define USBIFM_FLG_RXACT   1
`define USBIFM_FLG_RXERR   0

// Line state codes from the transceiver
`define USBIFM_LS_SE0 2'h0
`define USBIFM_LS_J   2'h1
`define USBIFM_LS_K   2'h2

`define USBIFM_EP_VALID_BIT 4
`define USBIFM_EP_MARK      5'h10

`endif

// ===== pkg/usbifm_pkg.sv
// Purpose: Types shared by the USB interface manager status block.
// Assumes: Nothing beyond the constants header.
// Notes:   All block state is one packed struct.
package usbifm_pkg;

  typedef struct packed {
    logic [6:0]  device_address;
    logic [3:0]  serial_ctrl;     // se0, data, enable_low, fsls
    logic [6:0]  event_flags;
    logic [6:0]  hold_select;
    logic [31:0] port_masks;
    logic [10:0] frame_count;
    logic [3:0]  last_pid;
    logic [4:0]  last_endpoint;
    logic [15:0] endpoint_marks;
    logic [31:0] read_data;
    logic        read_valid;
    logic [4:0]  rx_endpoint;
    logic        rx_endpoint_valid;
  } usbifm_state_t;

endpackage : usbifm_pkg

// ===== test/usbifm_phy_model.sv
// Purpose: Behavioural transceiver driving session, line and receive levels.
// Assumes: The bench picks the line symbol; levels follow one clock later.
// Notes:   Code 3 shows no symbol, as a released bus would.
`timescale 1ns/1ps
module usbifm_phy_model (
  // Clock and stimulus
  input  wire logic       clock_in,
  input  wire logic [1:0] line_code_in,
  input  wire logic [5:0] session_in,
  // Transceiver levels
  output logic      [5:0] session_out,
  output logic      [2:0] rx_out,
  output logic      [1:0] line_out
);
  always_ff @(posedge clock_in) begin
    session_out <= session_in;
    line_out    <= line_code_in;
    rx_out      <= {line_code_in == 2'h1, line_code_in == 2'h2,
                    line_code_in == 2'h1};
  end
endmodule : usbifm_phy_model

// ===== test/usbifm_status_regs_asserts.sv
// Purpose: Port assertions for the interface manager status block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Soft reset may land one or two edges after its write.
`timescale 1ns/1ps
module usbifm_status_regs_asserts (
  // Clock, reset and register port
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        reg_rdata_valid_out,
  // Token and outputs
  input wire logic        token_valid_in,
  input wire logic [3:0]  token_endpoint_in,
  input wire logic        transmit_single_ended_zero_out,
  input wire logic        serial_transmit_value_out,
  input wire logic        transmit_enable_low_out,
  input wire logic        full_low_speed_serial_select_out,
  input wire logic [3:0]  event_port_out,
  input wire logic [4:0]  rx_endpoint_out,
  input wire logic        rx_endpoint_valid_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic ser_wr;
  assign ser_wr = reg_write_in && reg_addr_in == 8'h18;
  a_read_answer: assert property (reg_read_in |=> reg_rdata_valid_out)
    else $error("read not answered");
  a_rdata_quiet: assert property (!reg_rdata_valid_out |->
    reg_rdata_out == 32'h0) else $error("read data not idle");
  a_se0_write: assert property (ser_wr |=>
    transmit_single_ended_zero_out == $past(reg_wdata_in[3]))
    else $error("se0 request wrong");
  a_txdata_write: assert property (ser_wr |=>
    serial_transmit_value_out == $past(reg_wdata_in[2]))
    else $error("transmit data wrong");
  a_txen_write: assert property (ser_wr |=>
    transmit_enable_low_out == $past(reg_wdata_in[1]))
    else $error("transmit enable wrong");
  a_fsls_write: assert property (ser_wr |=>
    full_low_speed_serial_select_out == $past(reg_wdata_in[0]))
    else $error("serial mode wrong");
  a_soft_reset: assert property (reg_write_in && reg_addr_in == 8'h0
    |-> ##[1:2] (transmit_enable_low_out && !full_low_speed_serial_select_out))
    else $error("soft reset missed");
  a_endpoint_seen: assert property (rx_endpoint_valid_out |->
    $past(token_valid_in) && rx_endpoint_out[3:0] == $past(token_endpoint_in))
    else $error("endpoint output wrong");
  a_masks_off: assert property (reg_write_in && reg_addr_in == 8'h24 &&
    reg_wdata_in == 32'h0 |=> event_port_out == 4'h0)
    else $error("event port with no mask");
endmodule : usbifm_status_regs_asserts
bind usbifm_status_regs usbifm_status_regs_asserts u_asserts (.*);

// ===== test/test_usbifm_status_regs.sv
// Purpose: Self-checking bench for the interface manager status block.
// Assumes: Transceiver model feeds the line and session inputs.
// Notes:   Register rows first, then reset, token, flag and line cases.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_fail++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module test_usbifm_status_regs;
  typedef struct packed {logic [7:0] a; logic [31:0] d, e;} usbifm_row_t;
  usbifm_row_t rows [10] = '{'{8'h18, '1, 32'h5f}, '{8'h14, '1, 32'h2a},
    '{8'h20, '1, 32'h7f}, '{8'h24, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{8'h28, '1, 32'h7ff}, '{8'h2c, '1, 32'h0}, '{8'h30, '1, 32'h0},
    '{8'h34, '1, 32'hffff}, '{8'h08, '1, 32'h7f}, '{8'h3c, '1, 32'h0}};
  logic [31:0] exp_line [4] = '{32'h20, 32'h08, 32'h10, 32'h0};
  int n_fail = 0, samples_checked = 0, cycles = 0;
  logic clock_in = 0, rst_n_in = 0, reg_write_in = 0, reg_read_in = 0;
  logic [7:0] reg_addr_in = 8'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [5:0] session = 6'h2a, sess_w;
  logic [2:0] rx_w;
  logic [1:0] line_code = 2'h1, line_state_in;
  logic b_session_valid_flag_in, id_ground_flag_in, host_disconnect_flag_in;
  logic bus_voltage_valid_flag_in, session_valid_flag_in, session_end_flag_in;
  logic differential_receive_value_in, dminus_receive_value_in;
  logic dplus_receive_value_in, reg_rdata_valid_out, rx_endpoint_valid_out;
  logic transceiver_receive_active_in = 0, transceiver_receive_error_in = 0;
  logic packet_start_in = 0, pid_valid_in = 0, token_valid_in = 0;
  logic crc16_fail_in = 0, frame_start_valid_in = 0;
  logic [3:0] pid_in = 4'h0, token_endpoint_in = 4'h0, event_port_out;
  logic [6:0] token_address_in = 7'h0;
  logic [10:0] frame_number_in = 11'h0;
  logic transmit_single_ended_zero_out, serial_transmit_value_out;
  logic transmit_enable_low_out, full_low_speed_serial_select_out;
  logic [4:0] rx_endpoint_out;
  usbifm_phy_model phy (.clock_in(clock_in), .line_code_in(line_code),
    .session_in(session), .session_out(sess_w), .rx_out(rx_w),
    .line_out(line_state_in));
  assign {b_session_valid_flag_in, id_ground_flag_in, host_disconnect_flag_in,
    bus_voltage_valid_flag_in, session_valid_flag_in,
    session_end_flag_in} = sess_w;
  assign {differential_receive_value_in, dminus_receive_value_in,
    dplus_receive_value_in} = rx_w;
  usbifm_status_regs dut (.*);
  always #5 clock_in = ~clock_in;
  task automatic finish_test();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic pulse(ref logic s);
    @(negedge clock_in);
    s = 1'b1;
    @(negedge clock_in);
    s = 1'b0;
  endtask : pulse
  // Full 32-bit words only; the strobe is held across one sampling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock_in);
    {reg_write_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
    @(negedge clock_in);
    reg_write_in = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(negedge clock_in);
    {reg_read_in, reg_addr_in} = {1'b1, a};
    @(negedge clock_in);
    reg_read_in = 1'b0;
    `CHK(reg_rdata_valid_out, 1'b1)
    `CHK(reg_rdata_out, e)
  endtask : rd_chk
  task automatic token(input logic [6:0] a, input logic [3:0] ep);
    {token_address_in, token_endpoint_in} = {a, ep};
    pulse(token_valid_in);
  endtask : token
  initial begin
    // Hold reset for three cycles before the first register access
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("register rows done");
    rst_n_in = 1'b0;
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    `CHK(transmit_enable_low_out, 1'b1)
    `CHK(full_low_speed_serial_select_out, 1'b0)
    rd_chk(8'h18, 32'h52);
    rd_chk(8'h28, 32'h0);
    $display("reset test done");
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h5);
    wr(8'h34, 32'h8);
    token(7'h5, 4'h3);
    `CHK(rx_endpoint_valid_out, 1'b1)
    `CHK(rx_endpoint_out, 5'h13)
    rd_chk(8'h30, 32'h13);
    rd_chk(8'h1c, 32'h48);
    token(7'h6, 4'h3);
    `CHK(rx_endpoint_valid_out, 1'b0)
    $display("token test done");
    // Sticky CRC bit must survive the packet start that wipes the token bit
    wr(8'h20, 32'h4);
    {transceiver_receive_active_in, transceiver_receive_error_in} = 2'h3;
    pulse(crc16_fail_in);
    pulse(packet_start_in);
    rd_chk(8'h1c, 32'h0f);
    wr(8'h1c, 32'h4);
    rd_chk(8'h1c, 32'h0b);
    {transceiver_receive_active_in, transceiver_receive_error_in} = 2'h0;
    wr(8'h24, 32'h38);
    for (int c = 0; c < 4; c++) begin
      line_code = c[1:0];
      repeat (3) @(negedge clock_in);
      rd_chk(8'h1c, exp_line[c]);
      `CHK(event_port_out, {3'h0, exp_line[c] != 32'h0})
    end
    wr(8'h24, 32'h0);
    {pid_in, frame_number_in} = {4'ha, 11'h123};
    pulse(pid_valid_in);
    pulse(frame_start_valid_in);
    rd_chk(8'h2c, 32'ha);
    rd_chk(8'h28, 32'h123);
    $display("flag and line tests done");
    finish_test();
  end
endmodule : test_usbifm_status_regs
